// *** rtl/tmc_mode_ctrl.sv ***
// tmc_mode_ctrl: pin-level mode control of the transceiver
// assumes pins arrive asynchronously; control bits come from the register file on i_clk
`timescale 1ns/10ps
`default_nettype none

module tmc_mode_ctrl
   import tmc_pkg::*;
(
   input  wire logic                  i_clk,                  // 20 mhz clock
   input  wire logic                  i_reset_n,              // pin reset, active low
   input  wire logic                  i_sequence_trigger_input, // pin, active high
   input  wire logic                  i_wake_attention_input_n, // pin, active low
   input  wire logic                  i_test_mode_strap,      // pin, must be low
   input  wire logic                  i_seq_type,             // programmed type, 1 = tx
   input  wire logic                  i_alt_func_en,          // alternate gpio function enable
   input  wire logic                  i_sleep_req,            // request doze
   input  wire logic                  i_hibernate_req,        // request hibernate
   input  wire logic                  i_seq_done,             // sequence finished
   input  wire logic                  i_crc_valid,            // last received crc good
   input  wire logic [GPIO_WIDTH-1:0] i_gpio_out,             // gpio output values
   input  wire logic [GPIO_WIDTH-1:0] i_gpio_oe,              // gpio output enables
   input  wire logic [GPIO_WIDTH-1:0] i_gpio_pin,             // gpio pin levels
   output logic [GPIO_WIDTH-1:0]      o_gpio_pin,             // gpio pin drive
   output logic [GPIO_WIDTH-1:0]      o_gpio_pin_oe,          // gpio pin output enable
   output logic [GPIO_WIDTH-1:0]      o_gpio_in,              // synchronised gpio inputs
   output logic                       o_rx_active,            // receive sequence running
   output logic                       o_tx_active,            // transmit sequence running
   output logic                       o_out_of_idle,          // not idle
   output logic                       o_off,                  // device off
   output logic                       o_low_power,            // doze or hibernate
   output logic                       o_strap_fault           // test strap seen high
);

   logic [1:0]            trig_sync;
   logic [1:0]            wake_attention_input_sync;
   logic [1:0]            strap_sync;
   logic                  trig_prev;
   logic [GPIO_WIDTH-1:0] gin_sync0;
   logic [GPIO_WIDTH-1:0] gin_sync1;
   tmc_state_e            state;
   tmc_state_e            next_state;
   logic [GPIO_WIDTH-1:0] next_gpio_pin;
   logic [GPIO_WIDTH-1:0] next_gpio_oe;
   logic                  trig;
   logic                  trig_rise;
   logic                  crc_flag;
   logic                  next_crc_flag;
   logic                  next_rx_active;
   logic                  next_tx_active;
   logic                  next_out_of_idle;
   logic                  next_off;
   logic                  next_low_power;

   assign trig      = trig_sync[1];
   assign trig_rise = trig & ~trig_prev;

   // pin synchronisers
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         trig_sync  <= SYNC_CLEAR;
         // attention idles high, so no false wake follows reset
         wake_attention_input_sync  <= ~SYNC_CLEAR;
         strap_sync <= SYNC_CLEAR;
         trig_prev  <= 1'b0;
         gin_sync0  <= GPIO_CLEAR;
         gin_sync1  <= GPIO_CLEAR;
      end else begin
         trig_sync  <= {trig_sync[0], i_sequence_trigger_input};
         wake_attention_input_sync  <= {wake_attention_input_sync[0], i_wake_attention_input_n};
         strap_sync <= {strap_sync[0], i_test_mode_strap};
         trig_prev  <= trig;
         gin_sync0  <= i_gpio_pin;
         gin_sync1  <= gin_sync0;
      end
   end

   // mode sequencing
   always_comb begin
      next_state = state;
      case (state)
         TMC_OFF: begin
            next_state = TMC_IDLE;
         end
         TMC_IDLE: begin
            if (trig_rise) begin
               next_state = (i_seq_type == SEQ_IS_TX) ? TMC_TX : TMC_RX;
            end else if (i_hibernate_req) begin
               next_state = TMC_HIBERNATE;
            end else if (i_sleep_req) begin
               next_state = TMC_DOZE;
            end
         end
         TMC_RX, TMC_TX: begin
            if (!trig) begin
               next_state = TMC_IDLE;
            end
         end
         TMC_DOZE, TMC_HIBERNATE: begin
            if (!wake_attention_input_sync[1]) begin
               next_state = TMC_IDLE;
            end
         end
         default: begin
            next_state = TMC_IDLE;
         end
      endcase
   end

   // crc valid latched on completion of a receive, cleared on new receive start
   always_comb begin
      next_crc_flag = crc_flag;
      if (state == TMC_RX && i_seq_done) begin
         next_crc_flag = i_crc_valid;
      end else if (state == TMC_IDLE && next_state == TMC_RX) begin
         next_crc_flag = 1'b0;
      end
   end

   // gpio pin muxing, one entry per pin
   always_comb begin
      next_gpio_pin = i_gpio_out;
      next_gpio_oe  = i_gpio_oe;
      if (i_alt_func_en) begin
         next_gpio_pin[GP_TWO] = next_crc_flag;
         next_gpio_oe[GP_TWO]  = 1'b1;
         next_gpio_pin[GP_ONE] = (next_state != TMC_IDLE);
         next_gpio_oe[GP_ONE]  = 1'b1;
      end
   end

   // status follows the state being entered, so it changes on the same edge as state
   always_comb begin
      next_rx_active   = (next_state == TMC_RX);
      next_tx_active   = (next_state == TMC_TX);
      next_out_of_idle = (next_state != TMC_IDLE);
      next_off         = (next_state == TMC_OFF);
      next_low_power   = (next_state == TMC_DOZE) || (next_state == TMC_HIBERNATE);
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         state         <= TMC_OFF;
         crc_flag      <= 1'b0;
         o_gpio_pin    <= GPIO_CLEAR;
         o_gpio_pin_oe <= GPIO_CLEAR;
         o_gpio_in     <= GPIO_CLEAR;
         o_rx_active   <= 1'b0;
         o_tx_active   <= 1'b0;
         o_out_of_idle <= 1'b0;
         o_off         <= 1'b1;
         o_low_power   <= 1'b0;
         o_strap_fault <= 1'b0;
      end else begin
         state         <= next_state;
         crc_flag      <= next_crc_flag;
         o_gpio_pin    <= next_gpio_pin;
         o_gpio_pin_oe <= next_gpio_oe;
         o_gpio_in     <= gin_sync1;
         o_rx_active   <= next_rx_active;
         o_tx_active   <= next_tx_active;
         o_out_of_idle <= next_out_of_idle;
         o_off         <= next_off;
         o_low_power   <= next_low_power;
         o_strap_fault <= strap_sync[1];
      end
   end

   // checks
   reset_off_a: assert property (@(posedge i_clk) !i_reset_n |=> o_off && state == TMC_OFF)
      else $error("reset did not hold device off");
   reset_idle_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      $past(i_reset_n) && $past(state) == TMC_OFF |-> state == TMC_IDLE)
      else $error("reset release did not reach idle");
   start_seq_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      state == TMC_IDLE && trig_rise |=> (state == TMC_TX) == $past(i_seq_type == SEQ_IS_TX)
      && state != TMC_IDLE)
      else $error("trigger edge did not start chosen sequence");
   trig_low_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (state == TMC_RX || state == TMC_TX) && !trig |=> state == TMC_IDLE && !o_out_of_idle)
      else $error("trigger low did not force idle");
   wake_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (state == TMC_DOZE || state == TMC_HIBERNATE) && !wake_attention_input_sync[1] |=> state == TMC_IDLE)
      else $error("attention did not wake device");
   alt_idle_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      $past(i_alt_func_en) && $past(i_reset_n) |-> o_gpio_pin_oe[GP_ONE]
      && o_gpio_pin[GP_ONE] == (state != TMC_IDLE))
      else $error("pin one not showing out of idle");
   alt_crc_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      $past(i_alt_func_en) && $past(i_reset_n) |-> o_gpio_pin[GP_TWO] == crc_flag)
      else $error("pin two not showing crc valid");
   plain_gpio_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      !i_alt_func_en ##1 i_reset_n |-> o_gpio_pin == $past(i_gpio_out)
      && o_gpio_pin_oe == $past(i_gpio_oe))
      else $error("gpio not ordinary when alternate off");
   stay_asleep_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (state == TMC_DOZE || state == TMC_HIBERNATE) && wake_attention_input_sync[1] |=> state == $past(state))
      else $error("low power state left without attention");
   rx_status_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      state == TMC_RX |-> o_rx_active && !o_tx_active && o_out_of_idle)
      else $error("receive status outputs wrong");
   tx_status_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      state == TMC_TX |-> o_tx_active && !o_rx_active && o_out_of_idle)
      else $error("transmit status outputs wrong");
   off_status_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      o_off |-> !$past(i_reset_n))
      else $error("device off without reset");
   crc_latch_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      state == TMC_RX && i_seq_done |=> crc_flag == $past(i_crc_valid))
      else $error("crc result not latched at receive end");
   reset_outputs_a: assert property (@(posedge i_clk)
      !i_reset_n |=> o_gpio_pin_oe == GPIO_CLEAR && !o_rx_active && !o_tx_active)
      else $error("reset did not clear outputs");

endmodule

`default_nettype wire

// *** rtl/tmc_pkg.sv ***
// tmc_pkg: constants for the transceiver mode control pin block
// assumes a single 20 MHz clock domain, no software-visible registers
package tmc_pkg;
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned SYNC_STAGES   = 2;
   localparam int unsigned GPIO_WIDTH    = 2;
   localparam int unsigned GP_ONE        = 0;
   localparam int unsigned GP_TWO        = 1;
   localparam logic        SEQ_IS_RX     = 1'b0;
   localparam logic        SEQ_IS_TX     = 1'b1;
   localparam logic [1:0]  SYNC_CLEAR    = 2'h0;
   localparam logic [1:0]  GPIO_CLEAR    = 2'h0;

   typedef enum logic [2:0] {
      TMC_OFF,
      TMC_IDLE,
      TMC_RX,
      TMC_TX,
      TMC_DOZE,
      TMC_HIBERNATE
   } tmc_state_e;
endpackage

// *** testbench/tmc_host_model.sv ***
// tmc_host_model: host side driving the reset, trigger, attention and strap pins
// assumes the bench calls drive just after a rising clock edge
`timescale 1ns/10ps
`default_nettype none
module tmc_host_model (
   input  wire logic i_clk,     // bench clock
   output logic      o_reset_n, // reset pin
   output logic      o_trigger, // sequence trigger pin
   output logic      o_wake_attention_input_n,  // attention pin
   output logic      o_strap    // test strap pin
);
   initial begin
      o_reset_n = 1'b0;
      o_trigger = 1'b0;
      o_wake_attention_input_n  = 1'b1;
      o_strap   = 1'b0;
   end
   // trigger rises only after setup and falls once the sequence is over
   task automatic drive(input logic rst_n, input logic trig, input logic wake_attention_input_n);
      o_reset_n = rst_n;
      o_trigger = trig;
      o_wake_attention_input_n  = wake_attention_input_n;
   endtask
endmodule
`default_nettype wire

// *** testbench/tmc_mode_ctrl_tb.sv ***
// tmc_mode_ctrl_tb: self-checking bench for the mode control pin block
// assumes tmc_pkg and tmc_mode_ctrl are compiled first
`timescale 1ns/10ps
`default_nettype none
module tmc_mode_ctrl_tb;
   import tmc_pkg::*;
   logic       clk = 1'b0;
   logic       rst_n, trig, wake_attention_input_n, strap;
   logic       styp = 1'b0, alt = 1'b0, slp = 1'b0, hib = 1'b0, done = 1'b0, crc = 1'b0;
   logic [1:0] g_out = 2'h0, g_oe = 2'h0, g_pin = 2'h0, o_pin, o_oe, o_in;
   logic       rx, tx, ooi, off, lp, sf;
   int         err_count = 0, num_checks = 0, cyc = 0;
   always #25 clk = ~clk;
   tmc_host_model host (.i_clk(clk), .o_reset_n(rst_n), .o_trigger(trig), .o_wake_attention_input_n(wake_attention_input_n), .o_strap(strap));
   tmc_mode_ctrl dut (.i_clk(clk), .i_reset_n(rst_n), .i_sequence_trigger_input(trig),
      .i_wake_attention_input_n(wake_attention_input_n), .i_test_mode_strap(strap), .i_seq_type(styp), .i_alt_func_en(alt),
      .i_sleep_req(slp), .i_hibernate_req(hib), .i_seq_done(done), .i_crc_valid(crc), .i_gpio_out(g_out),
      .i_gpio_oe(g_oe), .i_gpio_pin(g_pin), .o_gpio_pin(o_pin), .o_gpio_pin_oe(o_oe), .o_gpio_in(o_in),
      .o_rx_active(rx), .o_tx_active(tx), .o_out_of_idle(ooi), .o_off(off), .o_low_power(lp), .o_strap_fault(sf));
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic check(input string name, input logic [1:0] seen, input logic [1:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic t_reset();
      step(20);
      check("off", off, 2'h1);
      check("strap", sf, 2'h0);
      host.drive(1'b1, 1'b0, 1'b1);
      step(2);
      check("off", off, 2'h0);
      check("ooi", ooi, 2'h0);
      $display("test reset done");
   endtask
   task automatic t_rx();
      alt  = 1'b1;
      styp = SEQ_IS_RX;
      host.drive(1'b1, 1'b1, 1'b1);
      step(4);
      check("rx", rx, 2'h1);
      check("pin_one", o_pin[GP_ONE], 2'h1);
      check("oe", o_oe, 2'h3);
      crc  = 1'b1;
      done = 1'b1;
      step(1);
      done = 1'b0;
      step(2);
      check("pin_two", o_pin[GP_TWO], 2'h1);
      host.drive(1'b1, 1'b0, 1'b1);
      step(4);
      check("rx", rx, 2'h0);
      check("pin_one", o_pin[GP_ONE], 2'h0);
      $display("test rx done");
   endtask
   task automatic t_tx();
      alt   = 1'b0;
      styp  = SEQ_IS_TX;
      g_out = 2'h2;
      g_oe  = 2'h3;
      g_pin = 2'h1;
      host.drive(1'b1, 1'b1, 1'b1);
      step(4);
      check("tx", tx, 2'h1);
      check("pins", o_pin, 2'h2);
      check("oe", o_oe, 2'h3);
      check("in", o_in, 2'h1);
      host.drive(1'b1, 1'b0, 1'b1);
      step(4);
      check("tx", tx, 2'h0);
      $display("test tx done");
   endtask
   task automatic t_wake();
      slp = 1'b1;
      step(4);
      slp = 1'b0;
      check("lp", lp, 2'h1);
      host.drive(1'b1, 1'b0, 1'b0);
      step(4);
      check("lp", lp, 2'h0);
      host.drive(1'b1, 1'b0, 1'b1);
      step(3);
      hib = 1'b1;
      step(2);
      hib = 1'b0;
      check("lp", lp, 2'h1);
      host.drive(1'b1, 1'b0, 1'b0);
      step(4);
      check("lp", lp, 2'h0);
      host.drive(1'b1, 1'b0, 1'b1);
      $display("test wake done");
   endtask
   task automatic t_midreset();
      step(2);
      alt  = 1'b1;
      styp = SEQ_IS_RX;
      host.drive(1'b1, 1'b1, 1'b1);
      step(4);
      check("rx", rx, 2'h1);
      check("pin_two", o_pin[GP_TWO], 2'h0);
      host.drive(1'b0, 1'b0, 1'b1);
      step(2);
      check("off", off, 2'h1);
      check("rx", rx, 2'h0);
      check("in", o_in, 2'h0);
      check("oe", o_oe, 2'h0);
      host.drive(1'b1, 1'b0, 1'b1);
      step(2);
      check("off", off, 2'h0);
      check("pin_one", o_pin[GP_ONE], 2'h0);
      check("oe", o_oe, 2'h3);
      $display("test midrun reset done");
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 1000) begin
         err_count++;
         end_of_test();
      end
   end
   initial begin
      t_reset();
      t_rx();
      t_tx();
      t_wake();
      t_midreset();
      end_of_test();
   end
endmodule
`default_nettype wire
